// [rtl/mofr_defines.svh]
// Constants for the macro opcode field router
`ifndef MOFR_DEFINES_SVH
`define MOFR_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define MOFR_IR_W 32
`define MOFR_OPND_W 6
`define MOFR_MAP_AW 10
`define MOFR_MAP_DEPTH 1024
`define MOFR_ENTRY_W 12
`define MOFR_MOD_W 4
`define MOFR_OPC_W 14
`define MOFR_POS_W 6
`define MOFR_WID_W 5

// ****************************************
// Field positions in the instruction word
// ****************************************
`define MOFR_OPC_HI 31
`define MOFR_OPC_LO 18
`define MOFR_MAP_HI 31
`define MOFR_MAP_LO 22
`define MOFR_MOD_HI 21
`define MOFR_MOD_LO 18
`define MOFR_FA_HI 17
`define MOFR_FA_LO 12
`define MOFR_FB_HI 11
`define MOFR_FB_LO 6
`define MOFR_FC_HI 5
`define MOFR_FC_LO 0
`define MOFR_POS_HI 23
`define MOFR_POS_LO 18
`define MOFR_WID_HI 4
`define MOFR_WID_LO 0

// ****************************************
// Reset values and the counter step
// ****************************************
`define MOFR_IR_RST 32'h0000_0000
`define MOFR_OPND_RST 6'h00
`define MOFR_ENTRY_RST 12'h000
`define MOFR_OPND_ONE 6'h01

`endif

// [rtl/mofr_pkg.sv]
// Types shared by the macro opcode field router files
`include "mofr_defines.svh"
package mofr_pkg;

	// Source of the destination operand counter load value
	typedef enum logic [1:0] {
		MOFR_CSRC_A,
		MOFR_CSRC_B,
		MOFR_CSRC_C
	} mofr_csrc_t;

	// Per-operand counter and address source control
	typedef struct packed {
		logic load;
		logic cnt_en;
		logic down;
		logic use_ucode;
	} mofr_opnd_ctl_t;

	// Control pipeline bits steering the block
	typedef struct packed {
		logic ir_load;
		logic map_we;
		mofr_csrc_t c_src;
		mofr_opnd_ctl_t a;
		mofr_opnd_ctl_t b;
		mofr_opnd_ctl_t c;
		logic [`MOFR_OPND_W-1:0] ucode_a;
		logic [`MOFR_OPND_W-1:0] ucode_b;
		logic [`MOFR_OPND_W-1:0] ucode_c;
	} mofr_ctl_t;

	// Register file addresses driven out
	typedef struct packed {
		logic [`MOFR_OPND_W-1:0] rd_a;
		logic [`MOFR_OPND_W-1:0] rd_b;
		logic [`MOFR_OPND_W-1:0] wr_a;
		logic [`MOFR_OPND_W-1:0] wr_b;
	} mofr_rf_addr_t;

endpackage : mofr_pkg

// [rtl/mofr_opnd_counter.sv]
// Loadable up/down operand address counter
`timescale 1ns/1ps
`include "mofr_defines.svh"
module mofr_opnd_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic load,
	input wire logic cnt_en,
	input wire logic down,
	input wire logic [`MOFR_OPND_W-1:0] din,
	// Count
	output logic [`MOFR_OPND_W-1:0] q
);
	logic [`MOFR_OPND_W-1:0] cnt_r;
	logic [`MOFR_OPND_W-1:0] cnt_nxt;

	// Load wins over counting so a fresh field is never skewed
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = din;
		end else if (cnt_en) begin
			cnt_nxt = down ? cnt_r - `MOFR_OPND_ONE : cnt_r + `MOFR_OPND_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_r <= `MOFR_OPND_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign q = cnt_r;

	// ****************************************
	// Checks
	// ****************************************
	cnt_step_a: assert property (@(posedge clk) disable iff (!rst_b)
		!load && cnt_en |=> cnt_r == ($past(down) ? $past(cnt_r) - `MOFR_OPND_ONE : $past(cnt_r) + `MOFR_OPND_ONE))
		else $error("operand counter did not step");
	cnt_load_a: assert property (@(posedge clk) disable iff (!rst_b)
		load |=> cnt_r == $past(din))
		else $error("operand counter did not load");

endmodule : mofr_opnd_counter

// [rtl/mofr_map_ram.sv]
// Opcode map memory: opcode index to microcode entry address
`timescale 1ns/1ps
`include "mofr_defines.svh"
module mofr_map_ram (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Address from the instruction register, used for read and write
	input wire logic [`MOFR_MAP_AW-1:0] addr,
	// Write side, shared with control store loading
	input wire logic we,
	input wire logic [`MOFR_ENTRY_W-1:0] wdata,
	// Entry address
	output logic [`MOFR_ENTRY_W-1:0] entry
);
	logic [`MOFR_ENTRY_W-1:0] mem_r [`MOFR_MAP_DEPTH];
	logic [`MOFR_ENTRY_W-1:0] mem_nxt [`MOFR_MAP_DEPTH];
	logic [`MOFR_ENTRY_W-1:0] entry_r;
	logic [`MOFR_ENTRY_W-1:0] entry_nxt;

	always_comb begin
		mem_nxt = mem_r;
		if (we) begin
			mem_nxt[addr] = wdata;
		end
		entry_nxt = mem_r[addr];
	end

	// Table contents are loaded by software, so only the output has a reset
	always_ff @(posedge clk) begin
		mem_r <= mem_nxt;
		if (!rst_b) begin
			entry_r <= `MOFR_ENTRY_RST;
		end else begin
			entry_r <= entry_nxt;
		end
	end

	assign entry = entry_r;

	// ****************************************
	// Checks
	// ****************************************
	sequence wr_then_hold_s;
		we ##1 (addr == $past(addr));
	endsequence
	map_write_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_then_hold_s |=> entry_r == $past(wdata, 2))
		else $error("map entry not returned after write");

endmodule : mofr_map_ram

// [rtl/mofr_router.sv]
// Macro opcode register and field router (top)
//
// What this block does
// - Hold macroinstruction in a 32-bit register.
// - Load fetched memory word before control acts.
// - Bits 31:18 form the macro opcode.
// - Bits 31:22 address the opcode map.
// - Bits 21:18 go to multi-way branch.
// - Bits 17:12 are first read address.
// - Bits 11:6 are second read address.
// - Bits 5:0 are destination write address.
// - Fields load counters; counters address register file.
// - Bits 23:18 feed ALU position mux.
// - Bits 4:0 feed ALU width mux.
// - Destination may take any operand field.
// - Read addresses use fixed fields, no mux.
// - Microcode may supply rd_a, rd_b and wr_a, not wr_b.
// - Whole instruction word available as data.
// - Opcode indexes the microcode entry address.
// - Map yields 12-bit entry to sequencer.
// - Instruction register addresses map on writes.
//
// The map table has no reset, so entry_addr means nothing until the
// entry for the current opcode has been written.
// Register file addresses leave through one register stage: microcode
// must steer use_ucode and the counters one cycle ahead of the access.
`timescale 1ns/1ps
`include "mofr_defines.svh"
module mofr_router (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Memory data word
	input wire logic [`MOFR_IR_W-1:0] mem_word,
	// Control pipeline
	input wire mofr_pkg::mofr_ctl_t ctl,
	// Map table load data
	input wire logic [`MOFR_ENTRY_W-1:0] map_wdata,
	// Instruction word and opcode
	output logic [`MOFR_IR_W-1:0] ir_word,
	output logic [`MOFR_OPC_W-1:0] opcode,
	// Sequencer
	output logic [`MOFR_ENTRY_W-1:0] entry_addr,
	output logic [`MOFR_MOD_W-1:0] branch_mod,
	// ALU multiplexers
	output logic [`MOFR_POS_W-1:0] alu_pos,
	output logic [`MOFR_WID_W-1:0] alu_width,
	// Register file addresses
	output mofr_pkg::mofr_rf_addr_t rf_addr
);
	import mofr_pkg::*;

	// ****************************************
	// Instruction register
	// ****************************************
	logic [`MOFR_IR_W-1:0] ir_r;
	logic [`MOFR_IR_W-1:0] ir_nxt;

	always_comb begin
		ir_nxt = ir_r;
		if (ctl.ir_load) begin
			ir_nxt = mem_word;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ir_r <= `MOFR_IR_RST;
		end else begin
			ir_r <= ir_nxt;
		end
	end

	// ****************************************
	// Field taps
	// ****************************************
	// Slices of ir_r are flip-flop outputs already; no extra stage.
	logic [`MOFR_OPND_W-1:0] fld_a;
	logic [`MOFR_OPND_W-1:0] fld_b;
	logic [`MOFR_OPND_W-1:0] fld_c;
	logic [`MOFR_MAP_AW-1:0] map_addr;

	assign ir_word = ir_r;
	assign opcode = ir_r[`MOFR_OPC_HI:`MOFR_OPC_LO];
	assign map_addr = ir_r[`MOFR_MAP_HI:`MOFR_MAP_LO];
	assign branch_mod = ir_r[`MOFR_MOD_HI:`MOFR_MOD_LO];
	assign alu_pos = ir_r[`MOFR_POS_HI:`MOFR_POS_LO];
	assign alu_width = ir_r[`MOFR_WID_HI:`MOFR_WID_LO];
	assign fld_a = ir_r[`MOFR_FA_HI:`MOFR_FA_LO];
	assign fld_b = ir_r[`MOFR_FB_HI:`MOFR_FB_LO];
	assign fld_c = ir_r[`MOFR_FC_HI:`MOFR_FC_LO];

	// ****************************************
	// Opcode map
	// ****************************************
	mofr_map_ram u_map (
		.clk(clk),
		.rst_b(rst_b),
		.addr(map_addr),
		.we(ctl.map_we),
		.wdata(map_wdata),
		.entry(entry_addr)
	);

	// ****************************************
	// Destination field select
	// ****************************************
	// Only the destination gets a mux: it is used late in the cycle,
	// while the read addresses sit on the critical path.
	logic [`MOFR_OPND_W-1:0] c_load_val;

	always_comb begin
		case (ctl.c_src)
			MOFR_CSRC_A: c_load_val = fld_a;
			MOFR_CSRC_B: c_load_val = fld_b;
			MOFR_CSRC_C: c_load_val = fld_c;
			default: c_load_val = fld_c;
		endcase
	end

	// ****************************************
	// Operand address counters
	// ****************************************
	logic [`MOFR_OPND_W-1:0] cnt_a;
	logic [`MOFR_OPND_W-1:0] cnt_b;
	logic [`MOFR_OPND_W-1:0] cnt_c;

	mofr_opnd_counter u_cnt_a (
		.clk(clk),
		.rst_b(rst_b),
		.load(ctl.a.load),
		.cnt_en(ctl.a.cnt_en),
		.down(ctl.a.down),
		.din(fld_a),
		.q(cnt_a)
	);

	mofr_opnd_counter u_cnt_b (
		.clk(clk),
		.rst_b(rst_b),
		.load(ctl.b.load),
		.cnt_en(ctl.b.cnt_en),
		.down(ctl.b.down),
		.din(fld_b),
		.q(cnt_b)
	);

	mofr_opnd_counter u_cnt_c (
		.clk(clk),
		.rst_b(rst_b),
		.load(ctl.c.load),
		.cnt_en(ctl.c.cnt_en),
		.down(ctl.c.down),
		.din(c_load_val),
		.q(cnt_c)
	);

	// ****************************************
	// Register file address outputs
	// ****************************************
	// One register stage so every output leaves from a flip-flop; the
	// address therefore follows the counter or microcode by one cycle.
	mofr_rf_addr_t rf_addr_r;
	mofr_rf_addr_t rf_addr_nxt;

	always_comb begin
		rf_addr_nxt.rd_a = ctl.a.use_ucode ? ctl.ucode_a : cnt_a;
		rf_addr_nxt.rd_b = ctl.b.use_ucode ? ctl.ucode_b : cnt_b;
		rf_addr_nxt.wr_a = ctl.c.use_ucode ? ctl.ucode_c : cnt_c;
		// Second write port always follows the destination counter
		rf_addr_nxt.wr_b = cnt_c;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rf_addr_r <= '{`MOFR_OPND_RST, `MOFR_OPND_RST, `MOFR_OPND_RST, `MOFR_OPND_RST};
		end else begin
			rf_addr_r <= rf_addr_nxt;
		end
	end

	assign rf_addr = rf_addr_r;

	// ****************************************
	// Checks
	// ****************************************
	sequence ir_load_s;
		ctl.ir_load ##0 rst_b;
	endsequence

	ir_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
		ir_load_s |=> ir_word == $past(mem_word))
		else $error("instruction word not captured on load");

	ir_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!ctl.ir_load |=> $stable(ir_word))
		else $error("instruction word changed without load");

	opc_fields_a: assert property (@(posedge clk) disable iff (!rst_b)
		ctl.ir_load |=> opcode == $past(mem_word[`MOFR_OPC_HI:`MOFR_OPC_LO])
			&& branch_mod == $past(mem_word[`MOFR_MOD_HI:`MOFR_MOD_LO]))
		else $error("opcode or modifier field wrong");

	alu_fields_a: assert property (@(posedge clk) disable iff (!rst_b)
		ctl.ir_load |=> alu_pos == $past(mem_word[`MOFR_POS_HI:`MOFR_POS_LO])
			&& alu_width == $past(mem_word[`MOFR_WID_HI:`MOFR_WID_LO]))
		else $error("position or width field wrong");

	sequence a_load_cnt_s;
		ctl.a.load && !ctl.a.use_ucode ##1 !ctl.a.use_ucode;
	endsequence
	rd_a_field_a: assert property (@(posedge clk) disable iff (!rst_b)
		a_load_cnt_s |=> rf_addr.rd_a == $past(fld_a, 2))
		else $error("first read address not from its field");

	sequence b_load_cnt_s;
		ctl.b.load ##1 !ctl.b.use_ucode;
	endsequence
	rd_b_field_a: assert property (@(posedge clk) disable iff (!rst_b)
		b_load_cnt_s |=> rf_addr.rd_b == $past(fld_b, 2))
		else $error("second read address not from its field");

	sequence c_load_s;
		ctl.c.load ##1 !ctl.c.use_ucode;
	endsequence
	wr_c_select_a: assert property (@(posedge clk) disable iff (!rst_b)
		c_load_s |=> rf_addr.wr_a == $past(c_load_val, 2) && rf_addr.wr_b == $past(c_load_val, 2))
		else $error("destination address not from selected field");

	ucode_src_a: assert property (@(posedge clk) disable iff (!rst_b)
		ctl.a.use_ucode && ctl.b.use_ucode && ctl.c.use_ucode
			|=> rf_addr.rd_a == $past(ctl.ucode_a) && rf_addr.rd_b == $past(ctl.ucode_b)
			&& rf_addr.wr_a == $past(ctl.ucode_c))
		else $error("microcode operand address not selected");

	sequence map_write_held_s;
		ctl.map_we ##1 !ctl.map_we && $stable(map_addr);
	endsequence
	entry_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
		map_write_held_s |=> entry_addr == $past(map_wdata, 2))
		else $error("entry address does not follow map write");

	// ****************************************
	// Reset checks
	// ****************************************
	// No disable here: these must see the reset cycles themselves.
	ir_reset_a: assert property (@(posedge clk)
		!rst_b |=> ir_word == `MOFR_IR_RST)
		else $error("instruction word not cleared by reset");

	entry_reset_a: assert property (@(posedge clk)
		!rst_b |=> entry_addr == `MOFR_ENTRY_RST)
		else $error("entry address not cleared by reset");

	rf_reset_a: assert property (@(posedge clk)
		!rst_b |=> rf_addr.rd_a == `MOFR_OPND_RST && rf_addr.rd_b == `MOFR_OPND_RST
			&& rf_addr.wr_a == `MOFR_OPND_RST && rf_addr.wr_b == `MOFR_OPND_RST)
		else $error("register file addresses not cleared by reset");

	// ****************************************
	// Field tap checks
	// ****************************************
	map_addr_tap_a: assert property (@(posedge clk) disable iff (!rst_b)
		ctl.ir_load |=> map_addr == $past(mem_word[`MOFR_MAP_HI:`MOFR_MAP_LO]))
		else $error("map address not from the top opcode bits");

	fields_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		!ctl.ir_load |=> $stable(opcode) && $stable(branch_mod) && $stable(alu_pos) && $stable(alu_width))
		else $error("instruction fields changed without load");

	rd_fixed_field_a: assert property (@(posedge clk) disable iff (!rst_b)
		ctl.a.load && ctl.b.load |=> cnt_a == $past(ir_word[`MOFR_FA_HI:`MOFR_FA_LO])
			&& cnt_b == $past(ir_word[`MOFR_FB_HI:`MOFR_FB_LO]))
		else $error("read counter loaded from another field");

	sequence c_own_load_s;
		ctl.c.load && ctl.c_src == MOFR_CSRC_C ##1 !ctl.c.use_ucode;
	endsequence
	wr_c_field_a: assert property (@(posedge clk) disable iff (!rst_b)
		c_own_load_s |=> rf_addr.wr_a == $past(fld_c, 2))
		else $error("destination address not from its own field");

	// ****************************************
	// Address source checks
	// ****************************************
	// Each of rd_a, rd_b and wr_a chooses counter or microcode on its own, every cycle; wr_b always takes the counter.
	rd_a_src_a: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b |=> rf_addr.rd_a == ($past(ctl.a.use_ucode) ? $past(ctl.ucode_a) : $past(cnt_a)))
		else $error("first read address from wrong source");

	rd_b_src_a: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b |=> rf_addr.rd_b == ($past(ctl.b.use_ucode) ? $past(ctl.ucode_b) : $past(cnt_b)))
		else $error("second read address from wrong source");

	wr_a_src_a: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b |=> rf_addr.wr_a == ($past(ctl.c.use_ucode) ? $past(ctl.ucode_c) : $past(cnt_c)))
		else $error("destination address from wrong source");

	wr_b_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b |=> rf_addr.wr_b == $past(cnt_c))
		else $error("second write address does not follow destination counter");

endmodule : mofr_router

// [dv/mofr_rf_model.sv]
// Register file model standing at the far side of the router
`timescale 1ns/1ps
module mofr_rf_model (
	// Clock
	input wire logic clk,
	// Addresses from the router
	input wire mofr_pkg::mofr_rf_addr_t rf_addr,
	// First write port
	input wire logic we,
	input wire logic [31:0] wdata,
	// First read port
	output logic [31:0] rd_data
);
	import mofr_pkg::*;
	logic [31:0] mem_r [0:63];
	// Any word, a whole instruction too, is stored as data
	always_ff @(posedge clk) begin
		if (we) begin
			mem_r[rf_addr.wr_a] <= wdata;
		end
	end
	// Read is asynchronous, as the read port feeds the ALU in the same cycle
	assign rd_data = mem_r[rf_addr.rd_a];
endmodule : mofr_rf_model

// [dv/mofr_router_bench.sv]
// Self-checking bench for the macro opcode field router
`timescale 1ns/1ps
module mofr_router_bench;
	import mofr_pkg::*;
	typedef struct packed {
		logic [31:0] word;
		mofr_csrc_t src;
		logic [11:0] entry;
	} mofr_row_t;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [31:0] mem_word = 32'h0;
	mofr_ctl_t ctl = '0;
	logic [11:0] map_wdata = 12'h000;
	logic [31:0] ir_word;
	logic [13:0] opcode;
	logic [11:0] entry_addr;
	logic [3:0] branch_mod;
	logic [5:0] alu_pos;
	logic [4:0] alu_width;
	mofr_rf_addr_t rf_addr;
	logic rf_we = 1'b0;
	logic [31:0] rf_rd;
	int num_errors = 0;
	int compares = 0;
	mofr_row_t rows [3] = '{'{32'h8A5C_F3A7, MOFR_CSRC_A, 12'h5A1},
		'{32'h1234_5678, MOFR_CSRC_B, 12'h0FF}, '{32'hFEDC_BA98, MOFR_CSRC_C, 12'hC3E}};

	mofr_router mofr_router_inst (.clk(clk), .rst_b(rst_b), .mem_word(mem_word), .ctl(ctl),
		.map_wdata(map_wdata), .ir_word(ir_word), .opcode(opcode), .entry_addr(entry_addr),
		.branch_mod(branch_mod), .alu_pos(alu_pos), .alu_width(alu_width), .rf_addr(rf_addr));
	mofr_rf_model mofr_rf_model_inst (.clk(clk), .rf_addr(rf_addr), .we(rf_we), .wdata(ir_word),
		.rd_data(rf_rd));

	always #5 clk = ~clk;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("Compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic load_ir(input logic [31:0] w);
		@(posedge clk);
		ctl.ir_load <= 1'b1;
		mem_word <= w;
		@(posedge clk);
		ctl.ir_load <= 1'b0;
	endtask : load_ir

	task automatic run_row(input mofr_row_t r);
		logic [5:0] dst;
		dst = (r.src == MOFR_CSRC_A) ? r.word[17:12] : (r.src == MOFR_CSRC_B) ? r.word[11:6] : r.word[5:0];
		load_ir(r.word);
		ctl.a.load <= 1'b1;
		ctl.b.load <= 1'b1;
		ctl.c.load <= 1'b1;
		ctl.c_src <= r.src;
		ctl.map_we <= 1'b1;
		map_wdata <= r.entry;
		@(posedge clk);
		ctl.a.load <= 1'b0;
		ctl.b.load <= 1'b0;
		ctl.c.load <= 1'b0;
		ctl.map_we <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(ir_word, r.word);
		chk(opcode, r.word[31:18]);
		chk(branch_mod, r.word[21:18]);
		chk(alu_pos, r.word[23:18]);
		chk(alu_width, r.word[4:0]);
		chk(entry_addr, r.entry);
		chk(rf_addr.rd_a, r.word[17:12]);
		chk(rf_addr.rd_b, r.word[11:6]);
		chk(rf_addr.wr_a, dst);
		chk(rf_addr.wr_b, dst);
	endtask : run_row

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(ir_word, 32'h0);
		chk(rf_addr, 32'h0);
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		// Word on the memory bus without a load request must not be taken
		@(posedge clk);
		mem_word <= 32'hFFFF_FFFF;
		repeat (3) @(posedge clk);
		#1;
		chk(ir_word, rows[2].word);
		// Same top bits, every lower bit flipped: only bits 31:22 may pick the entry
		load_ir({rows[0].word[31:22], ~rows[0].word[21:0]});
		repeat (2) @(posedge clk);
		#1;
		chk(entry_addr, rows[0].entry);
		// Earlier map write survives and is found again for the original word
		load_ir(rows[0].word);
		repeat (2) @(posedge clk);
		#1;
		chk(entry_addr, rows[0].entry);
		// Count up, count down, and a load that beats a count on the destination
		@(posedge clk);
		ctl.a.cnt_en <= 1'b1;
		ctl.b.cnt_en <= 1'b1;
		ctl.b.down <= 1'b1;
		ctl.c.load <= 1'b1;
		ctl.c.cnt_en <= 1'b1;
		ctl.c_src <= MOFR_CSRC_A;
		@(posedge clk);
		ctl.a <= '0;
		ctl.b <= '0;
		ctl.c <= '0;
		repeat (2) @(posedge clk);
		#1;
		chk(rf_addr.rd_a, 6'(rows[2].word[17:12] + 6'h01));
		chk(rf_addr.rd_b, 6'(rows[2].word[11:6] - 6'h01));
		chk(rf_addr.wr_a, rows[0].word[17:12]);
		// Microcode supplies rd_a, rd_b and wr_a; wr_b stays on the destination counter
		@(posedge clk);
		ctl.a.use_ucode <= 1'b1;
		ctl.b.use_ucode <= 1'b1;
		ctl.c.use_ucode <= 1'b1;
		ctl.ucode_a <= 6'h2A;
		ctl.ucode_b <= 6'h15;
		ctl.ucode_c <= 6'h33;
		repeat (2) @(posedge clk);
		#1;
		chk(rf_addr.rd_a, 6'h2A);
		chk(rf_addr.rd_b, 6'h15);
		chk(rf_addr.wr_a, 6'h33);
		chk(rf_addr.wr_b, rows[0].word[17:12]);
		// Instruction word written into the register file and read back
		@(posedge clk);
		rf_we <= 1'b1;
		ctl.ucode_a <= 6'h33;
		@(posedge clk);
		rf_we <= 1'b0;
		#1;
		chk(rf_rd, rows[0].word);
		// Second reset in mid-run clears the register and the addresses
		@(posedge clk);
		ctl <= '0;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(ir_word, 32'h0);
		chk(rf_addr, 32'h0);
		finish_test();
	end

	// Whole run is under a hundred cycles; this leaves ample margin
	initial begin
		#5000;
		num_errors++;
		finish_test();
	end
endmodule : mofr_router_bench
